// ==== inc/aors_pkg.sv ====
// Purpose: constants, types and helpers of the converter offset/result/timing block
// Assumes: byte registers on a 32-bit bus, one word per register
// Notes: byte address of a register is four times its index

package aors_pkg;

   // =========================================================
   // register map
   localparam int unsigned ADDR_W     = 14;
   localparam logic [11:0] IDX_CTRL   = 12'hf70;
   localparam logic [11:0] IDX_OFFSET = 12'hf75;
   localparam logic [11:0] IDX_RES_HI = 12'hf76;
   localparam logic [11:0] IDX_RES_LO = 12'hf77;
   localparam logic [11:0] IDX_TIMING = 12'hf78;

   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [7:0]  OFFSET_RST = 8'h00;
   localparam logic [7:0]  TIMING_RST = 8'h00;
   localparam logic [13:0] RESULT_RST = 14'h0000;
   localparam logic [7:0]  RES_LO_RST = 8'h00;
   localparam int unsigned BUSY_BIT   = 7;

   // =========================================================
   // fields and codes
   typedef struct packed {
      logic [1:0] reserved;
      logic [1:0] input_mode_select;
      logic       result_format_signed;
      logic       resolution_select;
      logic [1:0] start_code;
   } aors_ctrl_t;

   typedef struct packed {
      logic [3:0] sampling_time_field;
      logic [3:0] settling_time_field;
   } aors_timing_t;

   localparam logic [1:0]  START_NORMAL = 2'h1;
   localparam logic [1:0]  START_CAL    = 2'h2;
   localparam int unsigned CNT_W        = 11;
   localparam logic [10:0] SETTLE_FIXED = 11'h001;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'h0,
      ST_SAMPLE  = 2'h1,
      ST_SETTLE  = 2'h3,
      ST_CONVERT = 2'h2
   } aors_state_t;

   // =========================================================
   // helpers
   function automatic logic [10:0] sample_clocks(input logic [3:0] code);
      logic [10:0] n;
      n = 11'h002;
      unique case (code)
         4'h0, 4'h1: n = 11'h002;
         4'h2: n = 11'h004;
         4'h3: n = 11'h008;
         4'h4: n = 11'h010;
         4'h5: n = 11'h020;
         4'h6: n = 11'h040;
         4'h7: n = 11'h060;
         4'h8: n = 11'h080;
         4'h9: n = 11'h0c0;
         4'ha: n = 11'h100;
         4'hb: n = 11'h140;
         4'hc: n = 11'h180;
         4'hd: n = 11'h200;
         4'he: n = 11'h300;
         4'hf: n = 11'h400;
      endcase
      return n;
   endfunction

   // clears the two low bits that do not exist at 12-bit resolution
   function automatic logic [7:0] lo_mask(input logic res14, input logic [7:0] v);
      return res14 ? v : {v[7:2], 2'h0};
   endfunction

endpackage

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the converter offset, result and timing registers
// Assumes: ADC_DIV of 1, so one converter clock per core clock
// Notes: the bus driver notes expected read data; a monitor compares at each read answer
`timescale 1ns/10ps

module testbench;

   // =========================================================
   // signals
   logic                 core_clk;
   logic                 nrst;
   logic [13:0]          av_address;
   logic                 av_read;
   logic                 av_write;
   logic [31:0]          av_writedata;
   logic [31:0]          av_readdata;
   logic                 av_waitrequest;
   logic                 event_trigger;
   logic [13:0]          conv_raw;
   logic                 conv_done;
   logic                 sample_en;
   logic                 conv_start;
   logic                 conv_busy;
   aors_pkg::aors_ctrl_t conv_ctrl;

   int                   num_errors;
   int                   check_count;
   int                   cycles;
   int                   scnt;
   int                   setl;
   logic [31:0]          rq[$];
   int                   sq[$];
   int                   tq[$];
   int                   samp[16] = '{2, 2, 4, 8, 16, 32, 64, 96, 128, 192, 256, 320, 384, 512,
                                      768, 1024};
   logic [7:0]           off_v;
   logic [7:0]           tim_v;
   logic [13:0]          res_v;
   logic [7:0]           lat_v;
   logic                 cur_res;
   aors_pkg::aors_ctrl_t c;

   aors_top #(.ADC_DIV(1)) u_dut (
      .core_clk       (core_clk),
      .nrst           (nrst),
      .av_address     (av_address),
      .av_read        (av_read),
      .av_write       (av_write),
      .av_writedata   (av_writedata),
      .av_readdata    (av_readdata),
      .av_waitrequest (av_waitrequest),
      .event_trigger  (event_trigger),
      .conv_raw       (conv_raw),
      .conv_done      (conv_done),
      .sample_en      (sample_en),
      .conv_start     (conv_start),
      .conv_busy      (conv_busy),
      .conv_ctrl      (conv_ctrl)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // =========================================================
   // checking and closing
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      if (num_errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles > 40000)
      begin
         num_errors++;
         test_done();
      end
   end

   // read answers are compared against the oldest note
   always @(posedge core_clk)
   begin
      if (av_read === 1'b1 && av_waitrequest === 1'b0)
      begin
         if (rq.size() == 0)
            num_errors++;
         else
            chk(av_readdata, rq.pop_front());
      end
   end

   // sampling length, then settle length up to the conversion start pulse
   always @(posedge core_clk)
   begin
      if (sample_en === 1'b1)
      begin
         scnt++;
         setl = 0;
      end
      else if (scnt != 0)
      begin
         if (conv_start === 1'b1)
         begin
            chk(32'(scnt), 32'(sq.pop_front()));
            chk(32'(setl), 32'(tq.pop_front()));
            scnt = 0;
         end
         else
            setl++;
      end
   end

   // =========================================================
   // models of expected values
   function automatic logic [13:0] corr(logic [13:0] raw, logic [7:0] o, logic r14, logic sg);
      int d;
      d = int'($signed(raw)) - int'($signed(r14 ? o : {o[7:2], 2'h0}));
      if (!sg)
         return raw;
      if (d > 8191)
         d = 8191;
      if (d < -8192)
         d = -8192;
      return d[13:0];
   endfunction

   function automatic logic [7:0] cal(logic [13:0] raw, logic r14);
      int d;
      d = int'($signed(raw));
      if (d > 127)
         d = 127;
      if (d < -128)
         d = -128;
      return r14 ? d[7:0] : {d[7:2], 2'h0};
   endfunction

   // =========================================================
   // bus and converter tasks
   task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] d);
      av_address   <= {idx, 2'h0};
      av_write     <= wr;
      av_read      <= !wr;
      av_writedata <= {24'h0, d};
      do
         @(posedge core_clk);
      while (av_waitrequest !== 1'b0);
      av_read  <= 1'b0;
      av_write <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [11:0] idx, input logic [7:0] exp);
      rq.push_back({24'h0, exp});
      bus(1'b0, idx, 8'h00);
   endtask

   task automatic rd_hi();
      rd(aors_pkg::IDX_RES_HI, {2'h0, res_v[13:8]});
      lat_v = cur_res ? res_v[7:0] : {res_v[7:2], 2'h0};
   endtask

   task automatic conv(input aors_pkg::aors_ctrl_t cc, input logic evt, input logic [13:0] raw);
      sq.push_back(samp[tim_v[7:4]]);
      tq.push_back(cc.input_mode_select[1] ? int'(tim_v[3:0]) + 1 : 1);
      cur_res = cc.resolution_select;
      if (evt)
      begin
         bus(1'b1, aors_pkg::IDX_CTRL, {cc[7:2], 2'h0});
         event_trigger <= 1'b1;
         @(posedge core_clk);
         event_trigger <= 1'b0;
      end
      else
         bus(1'b1, aors_pkg::IDX_CTRL, cc);
      chk(32'(conv_ctrl), {24'h0, 2'h0, cc[5:2], 2'h0});
      while (conv_start !== 1'b1)
         @(posedge core_clk);
      // busy shows in the control register while the conversion runs
      rd(aors_pkg::IDX_CTRL, {1'b1, 1'b0, cc[5:2], 2'h0});
      conv_done <= 1'b1;
      conv_raw  <= raw;
      @(posedge core_clk);
      conv_done <= 1'b0;
      conv_raw  <= 14'($urandom);
      @(posedge core_clk);
      while (conv_busy === 1'b1)
         @(posedge core_clk);
      if (cc.start_code == aors_pkg::START_CAL)
         off_v = cal(raw, cur_res);
      else
         res_v = corr(raw, off_v, cur_res, cc.result_format_signed);
   endtask

   // =========================================================
   // main sequence
   initial
   begin
      nrst = 1'b0;
      av_address = 14'h0000;
      av_read = 1'b0;
      av_write = 1'b0;
      av_writedata = 32'h0;
      event_trigger = 1'b0;
      conv_raw = 14'h0000;
      conv_done = 1'b0;
      num_errors = 0;
      check_count = 0;
      cycles = 0;
      scnt = 0;
      setl = 0;
      res_v = 14'h0000;
      tim_v = 8'h00;
      cur_res = 1'b0;
      void'($urandom(32'hb7bffe74));
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(aors_pkg::IDX_OFFSET, 8'h00);
      rd(aors_pkg::IDX_RES_HI, 8'h00);
      rd(aors_pkg::IDX_RES_LO, 8'h00);
      rd(aors_pkg::IDX_TIMING, 8'h00);
      bus(1'b1, 12'h100, 8'hff);
      rd(12'h100, 8'h00);
      off_v = 8'($urandom);
      bus(1'b1, aors_pkg::IDX_OFFSET, off_v);
      rd(aors_pkg::IDX_OFFSET, off_v);
      // every resolution and format pair, with the read-only high byte written
      for (int k = 0; k < 4; k++)
      begin
         c = {2'h0, 2'h0, k[1], k[0], aors_pkg::START_NORMAL};
         conv(c, 1'b0, 14'($urandom));
         bus(1'b1, aors_pkg::IDX_RES_HI, 8'hff);
         rd_hi();
         rd(aors_pkg::IDX_RES_LO, lat_v);
      end
      // low byte keeps the copy taken at the high read across a new result
      c = {2'h0, 2'h0, 1'b1, 1'b1, aors_pkg::START_NORMAL};
      conv(c, 1'b0, 14'($urandom));
      rd_hi();
      conv(c, 1'b0, 14'($urandom));
      rd(aors_pkg::IDX_RES_LO, lat_v);
      rd_hi();
      rd(aors_pkg::IDX_RES_LO, lat_v);
      // calibration runs at both resolutions leave results alone
      c = {2'h0, 2'h0, 1'b1, 1'b1, aors_pkg::START_CAL};
      conv(c, 1'b0, 14'h3ffa);
      rd(aors_pkg::IDX_OFFSET, off_v);
      c = {2'h0, 2'h0, 1'b1, 1'b0, aors_pkg::START_CAL};
      conv(c, 1'b0, 14'h0017);
      rd(aors_pkg::IDX_OFFSET, off_v);
      rd_hi();
      // unsigned use: software saves and clears the offset
      rd(aors_pkg::IDX_OFFSET, off_v);
      off_v = 8'h00;
      bus(1'b1, aors_pkg::IDX_OFFSET, off_v);
      c = {2'h0, 2'h0, 1'b0, 1'b1, aors_pkg::START_NORMAL};
      conv(c, 1'b0, 14'($urandom));
      rd_hi();
      rd(aors_pkg::IDX_RES_LO, lat_v);
      // every sampling code, every input mode, software and event starts
      for (int i = 0; i < 16; i++)
      begin
         tim_v = {4'(i), 4'($urandom)};
         bus(1'b1, aors_pkg::IDX_TIMING, tim_v);
         rd(aors_pkg::IDX_TIMING, tim_v);
         c = {2'h0, 2'(i), 1'b0, 1'b1, aors_pkg::START_NORMAL};
         conv(c, i[0], 14'($urandom));
      end
      repeat (4) @(posedge core_clk);
      test_done();
   end

endmodule

// ==== verilog/aors_top.sv ====
// Purpose: offset calibration, split result and sample timing of the converter
// Assumes: converter core on core_clk returns conv_raw with a conv_done pulse
// Notes: converter clock is a one-cycle enable every ADC_DIV core clocks
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/10ps

module aors_top #(
   parameter int unsigned ADC_DIV = 4
)(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // avalon-mm slave
   input  wire logic [13:0] av_address,
   input  wire logic        av_read,
   input  wire logic        av_write,
   input  wire logic [31:0] av_writedata,
   output logic      [31:0] av_readdata,
   output logic             av_waitrequest,
   // event system
   input  wire logic        event_trigger,
   // converter core
   input  wire logic [13:0] conv_raw,
   input  wire logic        conv_done,
   output logic             sample_en,
   output logic             conv_start,
   output logic             conv_busy,
   output aors_pkg::aors_ctrl_t conv_ctrl
);

   // =========================================================
   // reset release
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // =========================================================
   // converter clock enable
   localparam logic [7:0] DIV_LAST = 8'(ADC_DIV - 1);
   logic [7:0] div_r;
   logic       adc_ce;

   assign adc_ce = (div_r == DIV_LAST);

   always_ff @(posedge core_clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
         div_r <= 8'h00;
      else if (adc_ce)
         div_r <= 8'h00;
      else
         div_r <= div_r + 8'h01;
   end

   // =========================================================
   // bus slave: one wait cycle per access
   logic        ack_r;
   logic        wr_en;
   logic        rd_en;
   logic [11:0] idx;
   logic [7:0]  rd_mux;
   logic [31:0] rdata_r;

   assign idx            = av_address[13:2];
   assign av_waitrequest = (av_read | av_write) & ~ack_r;
   assign wr_en          = av_write & ack_r;
   assign rd_en          = av_read & ack_r;
   assign av_readdata    = rdata_r;

   always_ff @(posedge core_clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
         ack_r <= 1'b0;
      else
         ack_r <= (av_read | av_write) & ~ack_r;
   end

   // =========================================================
   // registers
   aors_pkg::aors_ctrl_t   ctrl_r;
   aors_pkg::aors_timing_t timing_r;
   aors_pkg::aors_state_t  state_r;
   logic [7:0]  offset_r;
   logic [13:0] result_r;
   logic [7:0]  res_lo_r;
   logic        cal_r;
   logic        res14;
   logic        done_ok;

   assign res14   = ctrl_r.resolution_select;
   assign done_ok = conv_done & (state_r == aors_pkg::ST_CONVERT);

   always_comb
   begin
      rd_mux = 8'h00;
      unique case (idx)
         aors_pkg::IDX_CTRL:
         begin
            rd_mux = {conv_busy, 1'b0, ctrl_r[5:2], 2'h0};
         end
         aors_pkg::IDX_OFFSET: rd_mux = offset_r;
         aors_pkg::IDX_RES_HI: rd_mux = {2'h0, result_r[13:8]};
         aors_pkg::IDX_RES_LO: rd_mux = res_lo_r;
         aors_pkg::IDX_TIMING: rd_mux = timing_r;
         default:              rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
         rdata_r <= 32'h0000_0000;
      else if (av_read & ~ack_r)
         rdata_r <= {24'h00_0000, rd_mux};
   end

   always_ff @(posedge core_clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
         ctrl_r <= aors_pkg::CTRL_RST;
      else if (wr_en && idx == aors_pkg::IDX_CTRL)
         ctrl_r <= {2'h0, av_writedata[5:2], 2'h0};
   end

   always_ff @(posedge core_clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
         timing_r <= aors_pkg::TIMING_RST;
      else if (wr_en && idx == aors_pkg::IDX_TIMING)
         timing_r <= av_writedata[7:0];
   end

   assign conv_ctrl = ctrl_r;

   // =========================================================
   // correction and calibration arithmetic
   logic [13:0] frame;
   logic [7:0]  off_eff;
   logic [14:0] diff;
   logic [13:0] corr_val;
   logic [13:0] new_result;
   logic [7:0]  cal_val;

   assign frame   = {conv_raw[13:8], aors_pkg::lo_mask(res14, conv_raw[7:0])};
   assign off_eff = aors_pkg::lo_mask(res14, offset_r);
   assign diff    = {frame[13], frame} - {{7{off_eff[7]}}, off_eff};

   always_comb
   begin
      corr_val = diff[13:0];
      if (diff[14] != diff[13])
         corr_val = diff[14] ? 14'h2000 : 14'h1fff;
      corr_val = {corr_val[13:8], aors_pkg::lo_mask(res14, corr_val[7:0])};
   end

   // hardware correction only in signed format
   assign new_result = ctrl_r.result_format_signed ? corr_val : frame;

   always_comb
   begin
      cal_val = frame[7:0];
      if (frame[13:7] != {7{frame[13]}})
         cal_val = frame[13] ? 8'h80 : 8'h7f;
      cal_val = aors_pkg::lo_mask(res14, cal_val);
   end

   always_ff @(posedge core_clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
         offset_r <= aors_pkg::OFFSET_RST;
      else if (done_ok && cal_r)
         offset_r <= cal_val;
      else if (wr_en && idx == aors_pkg::IDX_OFFSET)
         offset_r <= av_writedata[7:0];
   end

   always_ff @(posedge core_clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
         result_r <= aors_pkg::RESULT_RST;
      else if (done_ok && !cal_r)
         result_r <= new_result;
   end

   // low byte follows only a completed high byte read
   always_ff @(posedge core_clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
         res_lo_r <= aors_pkg::RES_LO_RST;
      else if (rd_en && idx == aors_pkg::IDX_RES_HI)
         res_lo_r <= aors_pkg::lo_mask(res14, result_r[7:0]);
   end

   // =========================================================
   // sequencer: sample, settle, convert
   localparam int unsigned CNT_W = aors_pkg::CNT_W;
   logic              start_sw;
   logic              start_any;
   logic [1:0]        wr_code;
   logic [CNT_W-1:0]  cnt_r;
   logic [10:0]       settle_n;

   assign wr_code   = av_writedata[1:0];
   assign start_sw  = wr_en && idx == aors_pkg::IDX_CTRL &&
                      (wr_code == aors_pkg::START_NORMAL || wr_code == aors_pkg::START_CAL);
   assign start_any = start_sw | event_trigger;
   assign settle_n  = ctrl_r.input_mode_select[1] ?
                      {7'h00, timing_r.settling_time_field} + 11'h001
                      : aors_pkg::SETTLE_FIXED;
   assign sample_en = (state_r == aors_pkg::ST_SAMPLE);
   assign conv_busy = (state_r != aors_pkg::ST_IDLE);

   always_ff @(posedge core_clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         state_r    <= aors_pkg::ST_IDLE;
         cnt_r      <= '0;
         cal_r      <= 1'b0;
         conv_start <= 1'b0;
      end
      else
      begin
         conv_start <= 1'b0;
         unique case (state_r)
            aors_pkg::ST_IDLE:
            begin
               if (start_any)
               begin
                  state_r <= aors_pkg::ST_SAMPLE;
                  cnt_r   <= aors_pkg::sample_clocks(timing_r.sampling_time_field);
                  cal_r   <= start_sw && wr_code == aors_pkg::START_CAL;
               end
            end
            aors_pkg::ST_SAMPLE:
            begin
               if (adc_ce)
               begin
                  if (cnt_r == 11'h001)
                  begin
                     state_r <= aors_pkg::ST_SETTLE;
                     cnt_r   <= settle_n;
                  end
                  else
                     cnt_r <= cnt_r - 11'h001;
               end
            end
            aors_pkg::ST_SETTLE:
            begin
               if (adc_ce)
               begin
                  if (cnt_r == 11'h001)
                  begin
                     state_r    <= aors_pkg::ST_CONVERT;
                     conv_start <= 1'b1;
                  end
                  else
                     cnt_r <= cnt_r - 11'h001;
               end
            end
            aors_pkg::ST_CONVERT:
            begin
               if (conv_done)
                  state_r <= aors_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // =========================================================
   // checks
   a_sample_load: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      state_r == aors_pkg::ST_IDLE && start_any |=>
      cnt_r == aors_pkg::sample_clocks($past(timing_r.sampling_time_field)))
      else $error("sampling count not loaded from table");

   a_settle_fixed: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      $rose(state_r == aors_pkg::ST_SETTLE) && !ctrl_r.input_mode_select[1]
      |-> cnt_r == 11'h001)
      else $error("fixed settling is not one clock");

   a_settle_field: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      $rose(state_r == aors_pkg::ST_SETTLE) && ctrl_r.input_mode_select[1]
      |-> cnt_r == {7'h00, timing_r.settling_time_field} + 11'h001)
      else $error("settling count differs from field plus one");

   a_conv_order: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      conv_start |-> $past(state_r) == aors_pkg::ST_SETTLE &&
      state_r == aors_pkg::ST_CONVERT)
      else $error("conversion started outside settling end");

   a_cal_store: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      done_ok && cal_r |=> offset_r == $past(cal_val) && result_r == $past(result_r))
      else $error("calibration did not store offset");

   a_signed_corr: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      done_ok && !cal_r && ctrl_r.result_format_signed |=> result_r == $past(corr_val))
      else $error("signed result not corrected");

   a_unsigned_raw: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      done_ok && !cal_r && !ctrl_r.result_format_signed |=> result_r == $past(frame))
      else $error("unsigned result was altered");

   a_high_hold: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      !(done_ok && !cal_r) |=> $stable(result_r))
      else $error("result changed without a conversion");

   a_low_latch: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      rd_en && idx == aors_pkg::IDX_RES_HI |=>
      res_lo_r == aors_pkg::lo_mask($past(res14), $past(result_r[7:0])))
      else $error("low byte not latched on high read");

   a_low_stable: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      !(rd_en && idx == aors_pkg::IDX_RES_HI) |=> $stable(res_lo_r))
      else $error("low byte moved without high read");

   a_low_reserved: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      !res14 && $changed(res_lo_r) |-> res_lo_r[1:0] == 2'h0)
      else $error("12-bit low byte reserved bits set");

   a_sw_offset: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      wr_en && idx == aors_pkg::IDX_OFFSET && !(done_ok && cal_r) |=>
      offset_r == $past(av_writedata[7:0]))
      else $error("offset write lost");

   a_one_wait: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      av_waitrequest |=> !av_waitrequest)
      else $error("more than one wait cycle");

endmodule
